//--- design/tcs_defines.vh
// Register offsets, field positions, reset values and encodings of the timer.
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH
`define TCS_ADR_CTRL 8'h00
`define TCS_ADR_MODE 8'h04
`define TCS_ADR_FFCR 8'h08
`define TCS_ADR_CMP0 8'h0C
`define TCS_ADR_CMP1 8'h10
`define TCS_ADR_CAP0 8'h14
`define TCS_ADR_CAP1 8'h18
`define TCS_ADR_CNT 8'h1C
`define TCS_ADR_STAT 8'h20
`define TCS_ADR_MASK 8'h24
`define TCS_ADR_PRE 8'h28
`define TCS_CTRL_RUN 0
`define TCS_CTRL_START_SEL 1
`define TCS_CTRL_EDGE_SEL 2
`define TCS_CTRL_SYNC 3
`define TCS_CTRL_CLR1 4
`define TCS_MODE_CPM_LO 0
`define TCS_MODE_CPM_HI 1
`define TCS_MODE_SWCAP 2
`define TCS_FF_WR_LO 0
`define TCS_FF_WR_HI 1
`define TCS_FF_E0T1 2
`define TCS_FF_E1T1 3
`define TCS_FF_C0T1 4
`define TCS_FF_C1T1 5
`define TCS_FF_INV 2'h0
`define TCS_FF_SET 2'h1
`define TCS_FF_CLR 2'h2
`define TCS_FF_KEEP 2'h3
`define TCS_CPM_OFF 2'h0
`define TCS_CPM_IN01 2'h1
`define TCS_CPM_IN0RF 2'h2
`define TCS_CPM_TOG 2'h3
`define TCS_IRQ_CAP0 0
`define TCS_IRQ_CAP1 1
`define TCS_IRQ_CMP 2
`define TCS_CTRL_RST 8'h00
`define TCS_MODE_RST 8'h04
`define TCS_FFCR_RST 8'h03
`define TCS_PRE_RST 16'h0000
`endif

//--- design/tcs_edge_sync.v
// Three-stage pin synchroniser with rise and fall pulses.
`timescale 1ns/1ps
module tcs_edge_sync (
	input wire clk_i,
	input wire rst_i,
	input wire pin_i,
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg s1;
	reg s2;
	reg s3;
	reg lvl;
	// The first stage feeds only the second, so metastability stays contained.
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			lvl <= 1'b0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				lvl <= s3;
		end
	end
	assign level_o = lvl;
	assign rise_o = (s2 == s3) && s3 && !lvl;
	assign fall_o = (s2 == s3) && !s3 && lvl;
endmodule

//--- design/tcs_timer.v
// Capture and compare timer channel with a classic Wishbone register slave.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tcs_defines.vh"
// Functional notes
// - Start select 0 runs on own start bit; 1 waits for external trigger.
// - Trigger edge select 0 means rising, 1 falling edge of input 0.
// - Synchronous start wins over external trigger start when both chosen.
// - Sixteen-bit up-counter runs free on prescaler ticks during capture/compare.
// - Mode 01: input 0 rise to capture 0, input 1 rise to capture 1.
// - Mode 10: input 0 rise to capture 0, its fall to capture 1.
// - Mode 11: other timer toggle rise to capture 0, fall to capture 1.
// - Match enables 11 invert output flip-flop on each compare match.
// - Output flip-flop may invert on every capture 0 latch.
// - Counter equal to either compare register raises compare interrupt.
// - Writing flip-flop field: 00 inverts, 01 sets, 10 clears.
// - Writing 0 to software capture bit latches counter into capture 0.
module tcs_timer #(
	parameter CW = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire timer_input_0_i,
	input wire timer_input_1_i,
	input wire peer_toggle_i,
	input wire sync_start_i,
	output wire timer_output_pin_o,
	output wire irq_o
);
	reg [7:0] timer_control_reg;
	reg [7:0] timer_mode_reg;
	reg [7:0] toggle_ff_control;
	reg [CW-1:0] compare_reg_0;
	reg [CW-1:0] compare_reg_1;
	reg [CW-1:0] capture_reg_0;
	reg [CW-1:0] capture_reg_1;
	reg [CW-1:0] up_counter;
	reg [15:0] pre_div;
	reg [15:0] pre_cnt;
	reg [2:0] irq_stat;
	reg [2:0] irq_mask;
	reg output_toggle_ff;
	reg counting;
	reg [1:0] ff_wr;
	reg [2:0] next_stat;
	reg cap0_ev;
	reg cap1_ev;
	wire in0_lvl;
	wire in0_rise;
	wire in0_fall;
	wire in1_rise;
	wire tog_rise;
	wire tog_fall;
	wire sync_rise;
	wire wr;
	wire rd;
	wire tick;
	wire run_bit;
	wire count_start_select;
	wire trigger_edge_select;
	wire sync_sel;
	wire trig;
	wire [1:0] cpm;
	wire soft_hit;
	wire ff_flip;
	wire match0;
	wire match1;
	wire cmp_ev;

	tcs_edge_sync u_in0 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(timer_input_0_i),
		.level_o(in0_lvl),
		.rise_o(in0_rise),
		.fall_o(in0_fall)
	);
	tcs_edge_sync u_in1 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(timer_input_1_i),
		.level_o(),
		.rise_o(in1_rise),
		.fall_o()
	);
	tcs_edge_sync u_tog (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(peer_toggle_i),
		.level_o(),
		.rise_o(tog_rise),
		.fall_o(tog_fall)
	);
	tcs_edge_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(sync_start_i),
		.level_o(),
		.rise_o(sync_rise),
		.fall_o()
	);

	assign wr = cyc_i && stb_i && we_i && !ack_o;
	assign rd = cyc_i && stb_i && !we_i && !ack_o;
	assign run_bit = timer_control_reg[`TCS_CTRL_RUN];
	assign count_start_select = timer_control_reg[`TCS_CTRL_START_SEL];
	assign trigger_edge_select = timer_control_reg[`TCS_CTRL_EDGE_SEL];
	assign sync_sel = timer_control_reg[`TCS_CTRL_SYNC];
	assign cpm = timer_mode_reg[`TCS_MODE_CPM_HI:`TCS_MODE_CPM_LO];
	assign trig = trigger_edge_select ? in0_fall : in0_rise;
	assign tick = counting && (pre_cnt == pre_div);

	// Soft capture acts on the write edge itself, so it sees the counter
	// value that a read in the same cycle would return.
	assign soft_hit = wr && sel_i[0] && adr_i == `TCS_ADR_MODE &&
		!dat_i[`TCS_MODE_SWCAP];

	always @* begin
		cap0_ev = 1'b0;
		cap1_ev = 1'b0;
		case (cpm)
		`TCS_CPM_IN01: begin
			cap0_ev = in0_rise;
			cap1_ev = in1_rise;
		end
		`TCS_CPM_IN0RF: begin
			cap0_ev = in0_rise;
			cap1_ev = in0_fall;
		end
		`TCS_CPM_TOG: begin
			cap0_ev = tog_rise;
			cap1_ev = tog_fall;
		end
		default: begin
			cap0_ev = 1'b0;
			cap1_ev = 1'b0;
		end
		endcase
		if (soft_hit)
			cap0_ev = 1'b1;
	end
	// Matches fire once, on the tick that lands the counter on the value.
	assign match0 = tick && (up_counter + 1'b1 == compare_reg_0);
	assign match1 = tick && (up_counter + 1'b1 == compare_reg_1);
	assign cmp_ev = match0 || match1;

	// Start control: sync start first, then external trigger, then run bit.
	always @(posedge clk_i) begin
		if (rst_i || !run_bit) begin
			counting <= 1'b0;
		end else if (!counting) begin
			if (sync_sel)
				counting <= sync_rise;
			else if (count_start_select)
				counting <= trig;
			else
				counting <= 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i || !counting) begin
			pre_cnt <= 16'h0000;
		end else if (pre_cnt == pre_div) begin
			pre_cnt <= 16'h0000;
		end else begin
			pre_cnt <= pre_cnt + 16'h0001;
		end
	end

	// Compare 1 match may clear the counter when enabled; otherwise it wraps.
	always @(posedge clk_i) begin
		if (rst_i || !run_bit) begin
			up_counter <= {CW{1'b0}};
		end else if (tick) begin
			if (timer_control_reg[`TCS_CTRL_CLR1] && up_counter == compare_reg_1)
				up_counter <= {CW{1'b0}};
			else
				up_counter <= up_counter + 1'b1;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			capture_reg_0 <= {CW{1'b0}};
			capture_reg_1 <= {CW{1'b0}};
		end else begin
			if (cap0_ev)
				capture_reg_0 <= up_counter;
			if (cap1_ev)
				capture_reg_1 <= up_counter;
		end
	end

	// Simultaneous sources cancel in pairs, as each one inverts the level.
	assign ff_flip = (ff_wr == `TCS_FF_INV) ^
		(match0 && toggle_ff_control[`TCS_FF_E0T1]) ^
		(match1 && toggle_ff_control[`TCS_FF_E1T1]) ^
		(cap0_ev && toggle_ff_control[`TCS_FF_C0T1]) ^
		(cap1_ev && toggle_ff_control[`TCS_FF_C1T1]);

	// The flip-flop has no natural reset level; it starts low here.
	always @(posedge clk_i) begin
		if (rst_i) begin
			output_toggle_ff <= 1'b0;
		end else if (ff_wr == `TCS_FF_SET) begin
			output_toggle_ff <= 1'b1;
		end else if (ff_wr == `TCS_FF_CLR) begin
			output_toggle_ff <= 1'b0;
		end else begin
			output_toggle_ff <= output_toggle_ff ^ ff_flip;
		end
	end
	assign timer_output_pin_o = output_toggle_ff;

	// A new event in the clearing cycle keeps its status bit set.
	always @* begin
		next_stat = irq_stat;
		if (wr && adr_i == `TCS_ADR_STAT && sel_i[0])
			next_stat = next_stat & ~dat_i[2:0];
		if (cap0_ev)
			next_stat[`TCS_IRQ_CAP0] = 1'b1;
		if (cap1_ev)
			next_stat[`TCS_IRQ_CAP1] = 1'b1;
		if (cmp_ev)
			next_stat[`TCS_IRQ_CMP] = 1'b1;
	end
	assign irq_o = |(irq_stat & irq_mask);

	// Sixteen-bit registers take each byte lane on its own.
	always @(posedge clk_i) begin
		if (rst_i) begin
			compare_reg_0 <= {CW{1'b0}};
			compare_reg_1 <= {CW{1'b0}};
			pre_div <= `TCS_PRE_RST;
		end else begin
			if (wr && adr_i == `TCS_ADR_CMP0)
				compare_reg_0 <= {sel_i[1] ? dat_i[15:8] : compare_reg_0[15:8],
					sel_i[0] ? dat_i[7:0] : compare_reg_0[7:0]};
			if (wr && adr_i == `TCS_ADR_CMP1)
				compare_reg_1 <= {sel_i[1] ? dat_i[15:8] : compare_reg_1[15:8],
					sel_i[0] ? dat_i[7:0] : compare_reg_1[7:0]};
			if (wr && adr_i == `TCS_ADR_PRE)
				pre_div <= {sel_i[1] ? dat_i[15:8] : pre_div[15:8],
					sel_i[0] ? dat_i[7:0] : pre_div[7:0]};
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			timer_control_reg <= `TCS_CTRL_RST;
			timer_mode_reg <= `TCS_MODE_RST;
			toggle_ff_control <= `TCS_FFCR_RST;
			irq_stat <= 3'h0;
			irq_mask <= 3'h0;
			ff_wr <= `TCS_FF_KEEP;
		end else begin
			ack_o <= (wr || rd);
			irq_stat <= next_stat;
			ff_wr <= `TCS_FF_KEEP;
			if (wr && sel_i[0]) begin
				case (adr_i)
				`TCS_ADR_CTRL: timer_control_reg <= dat_i[7:0];
				`TCS_ADR_MODE: timer_mode_reg <= dat_i[7:0] | 8'h04;
				`TCS_ADR_FFCR: begin
					toggle_ff_control <= {dat_i[7:2], 2'h3};
					ff_wr <= dat_i[`TCS_FF_WR_HI:`TCS_FF_WR_LO];
				end
				`TCS_ADR_MASK: irq_mask <= dat_i[2:0];
				default: ;
				endcase
			end
			if (rd) begin
				case (adr_i)
				`TCS_ADR_CTRL: dat_o <= {24'h000000, timer_control_reg};
				`TCS_ADR_MODE: dat_o <= {24'h000000, timer_mode_reg};
				`TCS_ADR_FFCR: dat_o <= {24'h000000, toggle_ff_control};
				`TCS_ADR_CMP0: dat_o <= {16'h0000, compare_reg_0};
				`TCS_ADR_CMP1: dat_o <= {16'h0000, compare_reg_1};
				`TCS_ADR_CAP0: dat_o <= {16'h0000, capture_reg_0};
				`TCS_ADR_CAP1: dat_o <= {16'h0000, capture_reg_1};
				`TCS_ADR_CNT: dat_o <= {16'h0000, up_counter};
				`TCS_ADR_STAT: dat_o <= {24'h000000, in0_lvl, counting,
					output_toggle_ff, 2'h0, irq_stat};
				`TCS_ADR_MASK: dat_o <= {29'h00000000, irq_mask};
				`TCS_ADR_PRE: dat_o <= {16'h0000, pre_div};
				default: dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

//--- test/tcs_pulse_src.sv
// Model of the pulse sources on the timer input pins.
`timescale 1ns/1ps
module tcs_pulse_src (
	input wire clk_i,
	output logic [3:0] pin_o
);
	initial pin_o = 4'h0;
	// Each level stays 4 clocks so the pin synchroniser always takes it.
	task drive(input int idx, input logic lvl);
		pin_o[idx] <= lvl;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

//--- test/tcs_timer_asserts.sv
// Port checks of the timer: handshake, reset and output flip-flop.
`timescale 1ns/1ps
module tcs_timer_asserts (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire timer_output_pin_o,
	input wire irq_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire req = cyc_i && stb_i && !ack_o;
	wire ffw = req && we_i && adr_i == 8'h08;
	wire [1:0] ffc = dat_i[1:0];
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_ack_answer: assert property (req |=> ack_o)
		else $error("no ack");
	a_read_hold: assert property ($changed(dat_o) |-> $past(req && !we_i))
		else $error("read data moved");
	a_unmapped_zero: assert property (req && !we_i && adr_i == 8'h2C
		|=> dat_o == 32'h0) else $error("hole not zero");
	a_reset_quiet: assert property ($fell(rst_i)
		|-> !ack_o && !irq_o && !timer_output_pin_o)
		else $error("busy after reset");
	a_ff_set: assert property (ffw && ffc == 2'h1
		|-> ##2 timer_output_pin_o) else $error("ff not set");
	a_ff_clear: assert property (ffw && ffc == 2'h2
		|-> ##2 !timer_output_pin_o) else $error("ff not cleared");
	a_ff_invert: assert property (ffw && ffc == 2'h0
		|-> ##2 timer_output_pin_o != $past(timer_output_pin_o, 2))
		else $error("ff not inverted");
	c_ff_write: cover property (ffw);
	c_irq: cover property ($rose(irq_o));
	c_pin_rise: cover property ($rose(timer_output_pin_o));
endmodule
bind tcs_timer tcs_timer_asserts u_tcs_timer_asserts (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.timer_output_pin_o(timer_output_pin_o), .irq_o(irq_o));

//--- test/tcs_timer_tb.sv
// Self-checking bench of the capture and compare timer.
`timescale 1ns/1ps
`include "tcs_defines.vh"
module tcs_timer_tb;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
	logic we_i = 1'h0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, q, c;
	logic ack_o, tout, irq_o;
	logic [3:0] p;
	int bad_count = 0, compares = 0, n;
	tcs_pulse_src u_tcs_pulse_src (.clk_i(clk_i), .pin_o(p));
	tcs_timer u_tcs_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.timer_input_0_i(p[0]), .timer_input_1_i(p[1]),
		.peer_toggle_i(p[2]), .sync_start_i(p[3]),
		.timer_output_pin_o(tout), .irq_o(irq_o));
	initial forever #2 clk_i = ~clk_i;
	task chk(input logic [31:0] seen, exp, input string nm);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'h1);
		q = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'h0, a, 32'h0);
		chk(q, e, nm);
	endtask
	task finish_test;
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rd(`TCS_ADR_MODE, 32'h04, "mode");
		rd(`TCS_ADR_FFCR, 32'h03, "ffcr");
		rd(8'h2C, 32'h0, "hole");
		for (n = 0; n < 3; n++) begin
			wb(1'h1, `TCS_ADR_FFCR, (n + 1) % 3);
			chk(tout, n != 1, "ff pin");
		end
		// Counting must wait for the falling edge, not the rising one.
		wb(1'h1, `TCS_ADR_CTRL, 32'h07);
		u_tcs_pulse_src.drive(0, 1'h1);
		rd(`TCS_ADR_CNT, 32'h0, "cnt held");
		u_tcs_pulse_src.drive(0, 1'h0);
		repeat (2) @(posedge clk_i);
		wb(1'h0, `TCS_ADR_CNT, 32'h0);
		chk(q != 32'h0, 1'h1, "cnt run");
		wb(1'h1, `TCS_ADR_MASK, 32'h1);
		for (n = 1; n < 4; n++) begin
			wb(1'h1, `TCS_ADR_MODE, n + 4);
			u_tcs_pulse_src.drive(n == 3 ? 2 : 0, 1'h1);
			repeat (6) @(posedge clk_i);
			u_tcs_pulse_src.drive(n == 3 ? 2 : 2 - n, n == 1);
			u_tcs_pulse_src.drive(0, 1'h0);
			u_tcs_pulse_src.drive(1, 1'h0);
			chk(irq_o, 1'h1, "irq");
			wb(1'h1, `TCS_ADR_MASK, 32'h0);
			chk(irq_o, 1'h0, "irq masked");
			wb(1'h1, `TCS_ADR_MASK, 32'h1);
			wb(1'h1, `TCS_ADR_STAT, 32'h7);
			chk(irq_o, 1'h0, "irq cleared");
			wb(1'h0, `TCS_ADR_CAP0, 32'h0);
			c = q;
			wb(1'h0, `TCS_ADR_CAP1, 32'h0);
			chk(q - c, 32'hA, "cap gap");
		end
		wb(1'h1, `TCS_ADR_MODE, 32'h0);
		wb(1'h0, `TCS_ADR_CAP0, 32'h0);
		c = q;
		rd(`TCS_ADR_CNT, c + 32'h6, "soft cap");
		wb(1'h1, `TCS_ADR_CMP0, c + 32'h28);
		wb(1'h1, `TCS_ADR_CMP1, c + 32'h50);
		wb(1'h1, `TCS_ADR_FFCR, 32'h0E);
		n = 0;
		while (tout !== 1'h1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		while (tout === 1'h1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		chk(n, 32'h28, "pulse");
		@(posedge clk_i);
		wb(1'h0, `TCS_ADR_STAT, 32'h0);
		chk(q[2], 1'h1, "match flag");
		wb(1'h1, `TCS_ADR_FFCR, 32'h03);
		wb(1'h1, `TCS_ADR_FFCR, 32'h13);
		wb(1'h1, `TCS_ADR_MODE, 32'h0);
		chk(tout, 1'h1, "cap toggle");
		// Sync start must win over the rising trigger edge on input 0.
		wb(1'h1, `TCS_ADR_CTRL, 32'h0);
		wb(1'h1, `TCS_ADR_CTRL, 32'h0B);
		u_tcs_pulse_src.drive(0, 1'h1);
		rd(`TCS_ADR_CNT, 32'h0, "sync held");
		u_tcs_pulse_src.drive(3, 1'h1);
		repeat (2) @(posedge clk_i);
		rd(`TCS_ADR_CNT, 32'h2, "sync run");
		finish_test;
	end
endmodule
